/* shared/uart_ctrl_regs.vh */
// Register map, field positions, reset values and timing counts
// Assumes a 32-bit APB slave with one aligned word per register
`ifndef UART_CTRL_REGS_VH
`define UART_CTRL_REGS_VH

// ----------------------------------------------------------------
// Byte addresses
// ----------------------------------------------------------------
`define ADDR_STATUS      8'h00
`define ADDR_CTRL_FIRST  8'h04
`define ADDR_CTRL_SECOND 8'h08
`define ADDR_DATA        8'h0c
`define ADDR_DIVISOR     8'h10
`define ADDR_MODE        8'h14

// ----------------------------------------------------------------
// First control register fields
// ----------------------------------------------------------------
`define C1_GLOBAL_EN  7
`define C1_LEN9       6
`define C1_PARITY_EN  5
`define C1_PARITY_ODD 4
`define C1_STOP_TWO   3
`define C1_BREAK      2
`define C1_RX_NINTH   1
`define C1_TX_NINTH   0

// ----------------------------------------------------------------
// Second control register fields
// ----------------------------------------------------------------
`define C2_TX_EN      7
`define C2_RX_EN      6
`define C2_SPEED_HIGH 5
`define C2_ADDR_DET   4
`define C2_WAKE_EN    3
`define C2_RX_IE      2
`define C2_TX_IDLE_IE 1
`define C2_TX_EMPT_IE 0

// ----------------------------------------------------------------
// Mode register fields
// ----------------------------------------------------------------
`define MODE_UART_SEL 0
`define MODE_IRQ_FLAG 1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_CTRL_FIRST  8'h00
`define RST_CTRL_SECOND 8'h00
`define RST_DIVISOR     8'h00
`define RST_STATUS      8'h0b

// ----------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------
`define OS_PER_BIT      16
`define LOW_SPEED_PRE   2'h3
`define BREAK_BITS      13
`define SAMPLE_FIRST    4'h7
`define SAMPLE_LAST     4'h9
`define BIT_LAST        4'hf

`endif

/* verilog/uart_baud_gen.v */
// Baud rate generator giving a 16x oversample tick
// Assumes clear is held while the line logic is disabled
`timescale 1ns/10ps
`default_nettype none
`include "uart_ctrl_regs.vh"

module uart_baud_gen (
  input  wire       pclk,
  input  wire       presetn,
  input  wire       clk_en,
  input  wire       clear,
  input  wire       speed_high,
  input  wire [7:0] divisor,
  output reg        os_tick
);

  reg [7:0] count;
  reg [1:0] prescale;

  // ----------------------------------------------------------------
  // Divide by N+1, then by 4 more in low speed
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count    <= 8'h00;
      prescale <= 2'h0;
      os_tick  <= 1'b0;
    end else if (clk_en) begin
      os_tick <= 1'b0;
      if (clear) begin
        count    <= 8'h00;
        prescale <= 2'h0;
      end else if (count == divisor) begin
        count <= 8'h00;
        if (speed_high || prescale == `LOW_SPEED_PRE) begin
          prescale <= 2'h0;
          os_tick  <= 1'b1;
        end else begin
          prescale <= prescale + 2'h1;
        end
      end else begin
        count <= count + 8'h01;
      end
    end
  end

endmodule
`default_nettype wire

/* verilog/uart_control_options.v */
// UART with control registers, APB slave, transmitter and receiver
// Assumes a 32-bit APB master on pclk and a pad that honours tx_oe
//
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "uart_ctrl_regs.vh"

module uart_control_options (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        clk_en,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  input  wire        hs_clock_off,
  input  wire        rx_in,
  output reg         tx_out,
  output wire        tx_oe,
  output reg         wakeup_request,
  output wire        irq_request
);

  // ----------------------------------------------------------------
  // State codes
  // ----------------------------------------------------------------
  localparam [4:0] T_IDLE  = 5'h01;
  localparam [4:0] T_START = 5'h02;
  localparam [4:0] T_DATA  = 5'h04;
  localparam [4:0] T_STOP  = 5'h08;
  localparam [4:0] T_BREAK = 5'h10;
  localparam [3:0] R_IDLE  = 4'h1;
  localparam [3:0] R_START = 4'h2;
  localparam [3:0] R_DATA  = 4'h4;
  localparam [3:0] R_STOP  = 4'h8;

  // ----------------------------------------------------------------
  // Frame decoding
  // ----------------------------------------------------------------
  // Data bits in a word, parity taking the top slot when enabled
  function [3:0] data_bits;
    input len9;
    input pen;
    begin
      data_bits = (len9 ? 4'h9 : 4'h8) - {3'h0, pen};
    end
  endfunction

  function word_parity;
    input [8:0] w;
    input [3:0] n;
    input       odd;
    begin
      word_parity = ^(w & (9'h1ff >> (4'h9 - n))) ^ odd;
    end
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg        global_en;
  reg        data_len9;
  reg        parity_en;
  reg        parity_odd;
  reg        stop_two;
  reg        break_req;
  reg        tx_ninth;
  reg        rx_ninth;
  reg        tx_en;
  reg        rx_en;
  reg        speed_high;
  reg        addr_det;
  reg        wake_en;
  reg        rx_ie;
  reg        tx_idle_ie;
  reg        tx_empty_ie;
  reg  [7:0] divisor;
  reg        uart_mode;
  reg        irq_flag;
  reg        parity_err;
  reg        noise;
  reg        framing_err;
  reg        overrun;
  reg        rx_idle;
  reg        rx_avail;
  reg        tx_idle;
  reg        tx_empty;
  reg        status_seen;
  reg  [7:0] rx_data;
  reg  [8:0] tx_buf;

  wire       wr = psel && penable && pwrite;
  wire       rd = psel && penable && !pwrite;
  wire       next_global_en = (wr && paddr == `ADDR_CTRL_FIRST)
                              ? pwdata[`C1_GLOBAL_EN] : global_en;
  wire       active = global_en && uart_mode;
  wire       tx_run = active && tx_en;
  wire       rx_run = active && rx_en;
  wire [3:0] nbits  = data_bits(data_len9, parity_en);
  wire       os_tick;
  wire       data_rd = rd && paddr == `ADDR_DATA && status_seen;
  wire       data_wr = wr && paddr == `ADDR_DATA;

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  wire mapped = paddr == `ADDR_STATUS || paddr == `ADDR_CTRL_FIRST ||
                paddr == `ADDR_CTRL_SECOND || paddr == `ADDR_DATA ||
                paddr == `ADDR_DIVISOR || paddr == `ADDR_MODE;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // Read data captured in the setup phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (clk_en && psel && !penable) begin
      case (paddr)
        `ADDR_STATUS:
          prdata <= {24'h0, parity_err, noise, framing_err, overrun,
                     rx_idle, rx_avail, tx_idle, tx_empty};
        `ADDR_CTRL_FIRST:
          prdata <= {24'h0, global_en, data_len9, parity_en, parity_odd,
                     stop_two, break_req, rx_ninth, 1'b0};
        `ADDR_CTRL_SECOND:
          prdata <= {24'h0, tx_en, rx_en, speed_high, addr_det, wake_en,
                     rx_ie, tx_idle_ie, tx_empty_ie};
        `ADDR_DATA:    prdata <= {24'h0, rx_data};
        `ADDR_DIVISOR: prdata <= {24'h0, divisor};
        `ADDR_MODE:    prdata <= {30'h0, irq_flag, uart_mode};
        default:       prdata <= 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {global_en, data_len9, parity_en, parity_odd, stop_two,
       break_req} <= 6'h00;
      tx_ninth <= 1'b0;
      {tx_en, rx_en, speed_high, addr_det, wake_en, rx_ie, tx_idle_ie,
       tx_empty_ie} <= `RST_CTRL_SECOND;
      divisor   <= `RST_DIVISOR;
      uart_mode <= 1'b0;
    end else if (clk_en) begin
      if (wr) begin
        case (paddr)
          `ADDR_CTRL_FIRST: begin
            {global_en, data_len9, parity_en, parity_odd, stop_two,
             break_req} <= pwdata[7:2];
            tx_ninth <= pwdata[`C1_TX_NINTH];
          end
          `ADDR_CTRL_SECOND:
            {tx_en, rx_en, speed_high, addr_det, wake_en, rx_ie, tx_idle_ie,
             tx_empty_ie} <= pwdata[7:0];
          `ADDR_DIVISOR: divisor <= pwdata[7:0];
          `ADDR_MODE:    uart_mode <= pwdata[`MODE_UART_SEL];
          default: begin
          end
        endcase
      end
      // Only these bits drop; the rest keep the old setup
      if (!next_global_en) begin
        tx_en     <= 1'b0;
        rx_en     <= 1'b0;
        break_req <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Baud rate generator
  // ----------------------------------------------------------------
  uart_baud_gen baud (
    .pclk       (pclk),
    .presetn    (presetn),
    .clk_en     (clk_en),
    .clear      (!active),
    .speed_high (speed_high),
    .divisor    (divisor),
    .os_tick    (os_tick)
  );

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  reg [4:0] tx_state;
  reg [3:0] tx_os;
  reg [3:0] tx_bit;
  reg [8:0] tx_shift;
  reg       tx_par;
  reg       tx_second;
  reg [3:0] brk_bits;

  assign tx_oe = tx_run;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state  <= T_IDLE;
      tx_os     <= 4'h0;
      tx_bit    <= 4'h0;
      tx_shift  <= 9'h000;
      tx_par    <= 1'b0;
      tx_second <= 1'b0;
      brk_bits  <= 4'h0;
      tx_out    <= 1'b1;
      tx_buf    <= 9'h000;
      tx_empty  <= 1'b1;
      tx_idle   <= 1'b1;
    end else if (clk_en) begin
      if (data_wr) begin
        tx_buf   <= {tx_ninth & data_len9, pwdata[7:0]};
        tx_empty <= 1'b0;
        tx_idle  <= 1'b0;
      end
      if (!tx_run) begin
        tx_state <= T_IDLE;
        tx_out   <= 1'b1;
        tx_empty <= 1'b1;
        tx_idle  <= 1'b1;
      end else begin
        case (tx_state)
          T_IDLE: begin
            tx_out <= 1'b1;
            tx_os  <= 4'h0;
            if (!tx_empty) begin
              tx_shift <= tx_buf;
              tx_par   <= word_parity(tx_buf, nbits, parity_odd);
              tx_empty <= 1'b1;
              tx_state <= T_START;
            end else if (break_req) begin
              brk_bits <= 4'h0;
              tx_idle  <= 1'b0;
              tx_state <= T_BREAK;
            end else if (!data_wr) begin
              tx_idle <= 1'b1;
            end
          end
          T_START: begin
            tx_out <= 1'b0;
            tx_bit <= 4'h0;
            if (os_tick) begin
              tx_os <= tx_os + 4'h1;
              if (tx_os == `BIT_LAST)
                tx_state <= T_DATA;
            end
          end
          T_DATA: begin
            tx_out <= (parity_en && tx_bit == nbits) ? tx_par : tx_shift[0];
            if (os_tick) begin
              tx_os <= tx_os + 4'h1;
              if (tx_os == `BIT_LAST) begin
                tx_shift <= {1'b0, tx_shift[8:1]};
                tx_bit   <= tx_bit + 4'h1;
                tx_second <= 1'b0;
                // Word bits then the parity slot, if any
                if (tx_bit == nbits - {3'h0, !parity_en})
                  tx_state <= T_STOP;
              end
            end
          end
          T_STOP: begin
            tx_out <= 1'b1;
            if (os_tick) begin
              tx_os <= tx_os + 4'h1;
              if (tx_os == `BIT_LAST) begin
                tx_second <= 1'b1;
                if (!stop_two || tx_second)
                  tx_state <= T_IDLE;
              end
            end
          end
          T_BREAK: begin
            tx_out <= 1'b0;
            if (os_tick) begin
              tx_os <= tx_os + 4'h1;
              if (tx_os == `BIT_LAST && brk_bits != `BREAK_BITS)
                brk_bits <= brk_bits + 4'h1;
            end
            if (brk_bits == `BREAK_BITS && !break_req)
              tx_state <= T_IDLE;
          end
          default: tx_state <= T_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Receive pin conditioning
  // ----------------------------------------------------------------
  reg [2:0] rx_sync;
  reg       rx_level;
  reg       rx_prev;
  wire      rx_fall = rx_prev && !rx_level;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_sync        <= 3'h7;
      rx_level       <= 1'b1;
      rx_prev        <= 1'b1;
      wakeup_request <= 1'b0;
    end else if (clk_en) begin
      rx_sync <= {rx_sync[1:0], rx_in};
      if (rx_sync[1] == rx_sync[2])
        rx_level <= rx_sync[2];
      rx_prev        <= rx_level;
      wakeup_request <= rx_fall && wake_en && hs_clock_off;
    end
  end

  // ----------------------------------------------------------------
  // Receiver and its flags
  // ----------------------------------------------------------------
  reg [3:0] rx_state;
  reg [3:0] rx_os;
  reg [3:0] rx_bit;
  reg [8:0] rx_shift;
  reg [2:0] smp;
  wire      maj = (smp[0] & smp[1]) | (smp[1] & smp[2]) | (smp[0] & smp[2]);
  wire      disagree = !(smp == 3'h0 || smp == 3'h7);
  wire [8:0] rx_word = data_len9 ? rx_shift : {1'b0, rx_shift[8:1]};
  wire      addr_bit = rx_word[nbits - 4'h1];
  wire      rx_par_bad = parity_en &&
              (word_parity(rx_word, nbits, parity_odd) != rx_word[nbits]);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state    <= R_IDLE;
      rx_os       <= 4'h0;
      rx_bit      <= 4'h0;
      rx_shift    <= 9'h000;
      smp         <= 3'h7;
      rx_data     <= 8'h00;
      rx_ninth    <= 1'b0;
      rx_idle     <= 1'b1;
      rx_avail    <= 1'b0;
      overrun     <= 1'b0;
      framing_err <= 1'b0;
      parity_err  <= 1'b0;
      noise       <= 1'b0;
      status_seen <= 1'b0;
    end else if (clk_en) begin
      if (rd && paddr == `ADDR_STATUS)
        status_seen <= 1'b1;
      else if (rd && paddr == `ADDR_DATA)
        status_seen <= 1'b0;
      if (data_rd) begin
        rx_avail    <= 1'b0;
        overrun     <= 1'b0;
        framing_err <= 1'b0;
        parity_err  <= 1'b0;
        noise       <= 1'b0;
      end
      if (!rx_run) begin
        rx_state <= R_IDLE;
        rx_idle  <= 1'b1;
        if (!global_en || !rx_en) begin
          rx_avail    <= 1'b0;
          overrun     <= 1'b0;
          framing_err <= 1'b0;
          parity_err  <= 1'b0;
          noise       <= 1'b0;
        end
      end else begin
        case (rx_state)
          R_IDLE: begin
            rx_idle <= 1'b1;
            rx_os   <= 4'h0;
            rx_bit  <= 4'h0;
            if (rx_fall) begin
              rx_idle  <= 1'b0;
              rx_state <= R_START;
            end
          end
          R_START, R_DATA, R_STOP: begin
            if (os_tick) begin
              rx_os <= rx_os + 4'h1;
              if (rx_os >= `SAMPLE_FIRST && rx_os <= `SAMPLE_LAST)
                smp <= {smp[1:0], rx_level};
              if (rx_os == `BIT_LAST) begin
                if (rx_state == R_START) begin
                  rx_state <= maj ? R_IDLE : R_DATA;
                end else if (rx_state == R_DATA) begin
                  rx_shift <= {maj, rx_shift[8:1]};
                  rx_bit   <= rx_bit + 4'h1;
                  if (disagree)
                    noise <= 1'b1;
                  if (rx_bit == (data_len9 ? 4'h8 : 4'h7))
                    rx_state <= R_STOP;
                end else begin
                  rx_state <= R_IDLE;
                  if (addr_det && !addr_bit) begin
                    // Data word while waiting for an address
                  end else if (rx_avail && !data_rd) begin
                    overrun <= 1'b1;
                  end else begin
                    rx_data     <= rx_word[7:0];
                    rx_ninth    <= rx_word[8];
                    rx_avail    <= 1'b1;
                    framing_err <= !maj;
                    parity_err  <= rx_par_bad;
                    noise       <= noise | disagree;
                  end
                end
              end
            end
          end
          default: rx_state <= R_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Shared interrupt request flag, cleared by writing one
  // ----------------------------------------------------------------
  wire irq_set = (rx_ie && (rx_avail || overrun))
               || (tx_idle_ie && tx_idle)
               || (tx_empty_ie && tx_empty)
               || (rx_ie && wakeup_request);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_flag <= 1'b0;
    end else if (clk_en) begin
      if (irq_set)
        irq_flag <= 1'b1;
      else if (wr && paddr == `ADDR_MODE && pwdata[`MODE_IRQ_FLAG])
        irq_flag <= 1'b0;
    end
  end

  assign irq_request = irq_flag;

endmodule
`default_nettype wire

/* tb/uart_ctrl_sva.sv */
// Port checker for the UART control block
// Assumes clk_en high during APB writes
`timescale 1ns/10ps
`default_nettype none
`include "uart_ctrl_regs.vh"
module uart_ctrl_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        clk_en,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        hs_clock_off,
  input wire logic        tx_out,
  input wire logic        tx_oe,
  input wire logic        wakeup_request,
  input wire logic        irq_request
);
  // ------------------------------
  // Shadow of control bits
  // ------------------------------
  logic       g, t, m, wk;
  logic [2:0] ie;
  wire        wr = psel & penable & pwrite & clk_en;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {g, t, m, wk, ie} <= '0;
    end else if (wr) begin
      if (paddr == `ADDR_CTRL_FIRST) begin
        g <= pwdata[7];
        if (!pwdata[7]) t <= 1'b0;
      end
      if (paddr == `ADDR_CTRL_SECOND) begin
        t  <= pwdata[7] & g;
        wk <= pwdata[3];
        ie <= pwdata[2:0];
      end
      if (paddr == `ADDR_MODE) m <= pwdata[0];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_oe_enables: assert property (tx_oe == (g & t & m))
    else $error("tx_oe differs from enables");
  chk_oe_global: assert property (!g |-> !tx_oe)
    else $error("tx driven while disabled");
  chk_oe_mode: assert property (!m |-> !tx_oe)
    else $error("tx driven outside uart mode");
  chk_tx_abort: assert property (wr && paddr == `ADDR_CTRL_SECOND
    && !pwdata[7] |=> !tx_oe) else $error("tx not floated");
  chk_wake_clock: assert property (wakeup_request |-> hs_clock_off && wk)
    else $error("wake with clock on or disabled");
  chk_wake_pulse: assert property (wakeup_request |=> !wakeup_request)
    else $error("wake pulse too long");
  chk_irq_source: assert property ($rose(irq_request) |-> $past(|ie))
    else $error("irq without enable");
  chk_bit_length: assert property ($fell(tx_out) && tx_oe
    |=> (!tx_out || !tx_oe)[*8]) else $error("tx low bit too short");
  cover property ($rose(tx_oe));
  cover property ($rose(irq_request));
  cover property (wakeup_request);
endmodule
bind uart_control_options uart_ctrl_chk port_watch (.pclk, .presetn,
  .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .hs_clock_off,
  .tx_out, .tx_oe, .wakeup_request, .irq_request);
`default_nettype wire

/* tb/serial_peer.sv */
// Remote serial device driving the receive line
// Assumes the bit time is given in pclk cycles
`timescale 1ns/10ps
`default_nettype none
module serial_peer (
  input  wire logic pclk,
  output var  logic rx_line
);
  initial rx_line = 1'b1;
  // Frame bits LSB first, line left high
  task automatic send(input logic [9:0] bits, input int bt);
    for (int i = 0; i < 10; i++) begin
      @(posedge pclk);
      rx_line <= bits[i];
      repeat (bt - 1) @(posedge pclk);
    end
    repeat (bt) @(posedge pclk);
  endtask
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench for the UART control block
// Assumes zero-wait APB and a serial peer on the receive line
`timescale 1ns/10ps
`default_nettype none
`include "uart_ctrl_regs.vh"
`define CHECK(s, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  fails++; $display("CHECK FAILED %s exp %h got %h", s, e, g); end end
module tb_top;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        hs_clock_off = 0, err;
  logic [7:0]  paddr = 0, rd;
  logic [31:0] pwdata = 0, prdata;
  wire         pready, pslverr, rx_in, tx_out, tx_oe;
  wire         wakeup_request, irq_request;
  int          fails = 0, samples_checked = 0, wakes = 0, n;
  logic [7:0]  cfg [4] = '{8'h80, 8'ha0, 8'hb0, 8'hc9};
  logic [7:0]  tie [2] = '{8'he1, 8'he2};
  always #12.5 pclk = ~pclk;
  always @(posedge pclk) if (wakeup_request === 1'b1) wakes++;
  uart_control_options dut (.pclk, .presetn, .clk_en(1'b1), .psel,
    .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
    .hs_clock_off, .rx_in, .tx_out, .tx_oe, .wakeup_request, .irq_request);
  serial_peer peer (.pclk, .rx_line(rx_in));
  task automatic results;
    if (fails == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, d);
    int k = 0;
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, 24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++k < 50);
    if (k >= 50) begin fails++; results(); end
    rd = prdata[7:0];
    err = pslverr;
    {psel, penable} <= 2'b00;
    @(posedge pclk);
  endtask
  task automatic chk(input string s, input logic [7:0] a, e);
    apb(1'b0, a, 8'h00);
    `CHECK(s, e, rd)
  endtask
  // Expected serial bits: start, word, stop, then next sampled slot
  // Lead: cycles from the seen start bit to its first sample
  task automatic grab(input logic [7:0] c1, d, input logic nx,
                      input int lead);
    logic [8:0]  w;
    logic [11:0] f, got;
    int nb;
    w = {c1[0], d};
    nb = c1[6] ? 9 : 8;
    if (c1[5]) w[nb-1] = ^(w & ~(9'h1ff << (nb - 1))) ^ c1[4];
    f = 12'hfff;
    got = 12'hfff;
    f[0] = 1'b0;
    for (int i = 0; i < nb; i++) f[i+1] = w[i];
    f[nb+2] = nx;
    for (n = 0; tx_out !== 1'b0 && n < 2000; n++) @(posedge pclk);
    if (n >= 2000) begin fails++; results(); end
    repeat (lead) @(posedge pclk);
    for (int i = 0; i < nb + 3; i++) begin
      if (i > 0) repeat (16) @(posedge pclk);
      got[i] = tx_out;
    end
    `CHECK("frame", f, got)
  endtask
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    chk("status", `ADDR_STATUS, `RST_STATUS);
    chk("ctrl1", `ADDR_CTRL_FIRST, `RST_CTRL_FIRST);
    chk("ctrl2", `ADDR_CTRL_SECOND, `RST_CTRL_SECOND);
    chk("unmapped", 8'h18, 8'h00);
    `CHECK("slverr", 1'b1, err)
    apb(1'b1, `ADDR_MODE, 8'h01);
    apb(1'b1, `ADDR_DIVISOR, 8'h00);
    apb(1'b1, `ADDR_CTRL_FIRST, 8'h80);
    apb(1'b1, `ADDR_CTRL_SECOND, 8'he0);
    `CHECK("tx_oe", 1'b1, tx_oe)
    foreach (cfg[i]) begin
      apb(1'b1, `ADDR_CTRL_FIRST, cfg[i]);
      apb(1'b1, `ADDR_DATA, 8'h4b);
      apb(1'b1, `ADDR_DATA, 8'hb4);
      grab(cfg[i], 8'h4b, cfg[i][3], 8);
      grab(cfg[i], 8'hb4, 1'b1, cfg[i][3] ? 8 : 0);
    end
    apb(1'b1, `ADDR_CTRL_FIRST, 8'h80);
    apb(1'b1, `ADDR_CTRL_SECOND, 8'hf4);
    peer.send({1'b1, 8'h25, 1'b0}, 16);
    chk("dropped", `ADDR_STATUS, 8'h0b);
    `CHECK("irq_drop", 1'b0, irq_request)
    peer.send({1'b1, 8'ha5, 1'b0}, 16);
    chk("received", `ADDR_STATUS, 8'h0f);
    `CHECK("irq_rx", 1'b1, irq_request)
    chk("rxdata", `ADDR_DATA, 8'ha5);
    apb(1'b1, `ADDR_MODE, 8'h03);
    `CHECK("irq_clear", 1'b0, irq_request)
    foreach (tie[i]) begin
      apb(1'b1, `ADDR_CTRL_SECOND, tie[i]);
      @(posedge pclk);
      `CHECK("irq_tx", 1'b1, irq_request)
      apb(1'b1, `ADDR_CTRL_SECOND, 8'he0);
      apb(1'b1, `ADDR_MODE, 8'h03);
      @(posedge pclk);
      `CHECK("irq_off", 1'b0, irq_request)
    end
    apb(1'b1, `ADDR_DATA, 8'h00);
    apb(1'b1, `ADDR_CTRL_FIRST, 8'h30);
    `CHECK("abort_oe", 1'b0, tx_oe)
    chk("kept_ctrl2", `ADDR_CTRL_SECOND, 8'h20);
    chk("kept_ctrl1", `ADDR_CTRL_FIRST, 8'h30);
    chk("flags", `ADDR_STATUS, 8'h0b);
    apb(1'b1, `ADDR_CTRL_FIRST, 8'h80);
    apb(1'b1, `ADDR_CTRL_SECOND, 8'ha0);
    apb(1'b1, `ADDR_CTRL_FIRST, 8'h84);
    for (n = 0; tx_out !== 1'b0 && n < 100; n++) @(posedge pclk);
    for (n = 0; tx_out === 1'b0 && n < 300; n++) @(posedge pclk);
    `CHECK("break_len", 1'b1, n >= 13 * 16)
    apb(1'b1, `ADDR_CTRL_FIRST, 8'h80);
    for (n = 0; tx_out !== 1'b1 && n < 100; n++) @(posedge pclk);
    `CHECK("break_end", 1'b1, tx_out)
    apb(1'b1, `ADDR_CTRL_SECOND, 8'h4c);
    peer.send(10'h3fe, 16);
    `CHECK("no_wake", 0, wakes)
    hs_clock_off <= 1'b1;
    peer.send(10'h3fe, 16);
    `CHECK("wake", 1, wakes)
    hs_clock_off <= 1'b0;
    results();
  end
endmodule
`default_nettype wire
